// file: hdl/trd_regs.vh
`ifndef TRD_REGS_VH
`define TRD_REGS_VH
// ----------------------------------------
// Command field positions
// ----------------------------------------
`define TRD_EXP_HI 24
`define TRD_EXP_LO 20
`define TRD_MUL_HI 16
`define TRD_MUL_LO 12
`define TRD_GRAN_HI 75
`define TRD_GRAN_LO 74
`define TRD_HINT_HI 73
`define TRD_HINT_LO 72
`define TRD_CMD_W 128
// ----------------------------------------
// Granule select encodings
// ----------------------------------------
`define TRD_GRAN_ANY 2'h0
`define TRD_GRAN_4K 2'h1
`define TRD_GRAN_16K 2'h2
`define TRD_GRAN_64K 2'h3
// ----------------------------------------
// Level hint encodings
// ----------------------------------------
`define TRD_HINT_ANY 2'h0
`define TRD_HINT_L1 2'h1
`define TRD_HINT_L2 2'h2
`define TRD_HINT_L3 2'h3
// ----------------------------------------
// Command kinds
// ----------------------------------------
`define TRD_OP_GUEST_ALL 4'h0
`define TRD_OP_GUEST_SPACE 4'h1
`define TRD_OP_GUEST_VA_ALL 4'h2
`define TRD_OP_GUEST_VA 4'h3
`define TRD_OP_MON_ALL 4'h4
`define TRD_OP_MON_VA 4'h5
`define TRD_OP_HYP_ALL 4'h6
`define TRD_OP_HYP_VA 4'h7
`define TRD_OP_HYP_VA_ALL 4'h8
`define TRD_OP_HYP_SPACE 4'h9
// ----------------------------------------
// Translation regime tags
// ----------------------------------------
`define TRD_REG_NS_EL1 3'h0
`define TRD_REG_SEC 3'h1
`define TRD_REG_EL3 3'h2
`define TRD_REG_EL2 3'h3
`define TRD_REG_EL2_HOST 3'h4
// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define TRD_ADDR_W 64
`define TRD_END_W 65
`define TRD_ZERO_ADDR 64'h0
`define TRD_ZERO_END 65'h0
`endif

// file: hdl/trd_range_calc.v
`timescale 1ns/10ps
`include "trd_regs.vh"
// Combinational range end: start + (mult+1) << exp << granule shift
module trd_range_calc (
    // Inputs
    input wire [63:0] start_addr,
    input wire [1:0] granule_select,
    input wire [4:0] range_exp,
    input wire [4:0] range_mul,
    // Result
    output reg [64:0] end_addr
);
    reg [5:0] gshift;
    reg [6:0] total_shift;
    reg [127:0] span;
    reg [128:0] sum;
    always @* begin
        case (granule_select)
            `TRD_GRAN_4K: gshift = 6'h0C;
            `TRD_GRAN_16K: gshift = 6'h0E;
            `TRD_GRAN_64K: gshift = 6'h10;
            default: gshift = 6'h0C;
        endcase
        total_shift = {2'h0, range_exp} + {1'h0, gshift};
        span = {122'h0, {1'h0, range_mul} + 6'h01} << total_shift;
        // No wrap: an end at or past the top clamps to the top, so the low half is never reached
        sum = {65'h0, start_addr} + {1'h0, span};
        if (sum[128:64] != 65'h0) begin
            end_addr = {1'h1, 64'h0};
        end else begin
            end_addr = sum[64:0];
        end
    end
endmodule // trd_range_calc

// file: hdl/trd_decode.v
`timescale 1ns/10ps
`include "trd_regs.vh"
// Function
// - Range exponent at 24:20, multiplier at 16:12; zero-valued when unused.
// - Granule at 75:74, level hint at 73:72; hint never widens scope.
// - Granule 01=4KB, 10=16KB, 11=64KB; only matching granule entries.
// - One capability bit enables range and hint; else fields treated as zero.
// - Granule 00 ignores hint, no range; leaves at any level, any granule.
// - Nonzero granule: hint 00 any level, 01/10/11 select level 1/2/3.
// - 16KB granule treats reserved hint 01 as hint 00.
// - Range bytes equal (multiplier+1) times 2^exponent times granule size.
// - Invalidated addresses from start inclusive to start plus range exclusive.
// - Range past address top does not wrap to lower half.
// - Last-level flag 0 also invalidates table descriptors above the leaf level.
// - Nonzero granule with multiplier 0, exponent 0, hint 00 is illegal.
// - Broadcast maintenance support implies broadcast range invalidation support; flagged only when range support is also set.
// - Second-stage-only device rejects all first-stage invalidations.
// - Guest commands: non-secure queue EL1, secure queue secure regime.
// - Monitor commands illegal from non-secure queue; secure queue targets EL3.
// - Hyp commands target EL2 or host EL2 by mode; illegal without support.
// - Guest machine tag matched only when second stage exists for queue.
// - Optional out-of-range on unequal upper bits; optional top byte ignore.
module trd_decode (
    // Clock and reset
    input wire ref_clk,
    input wire rst_b,
    // Command from queue consumer
    input wire cmd_valid,
    input wire [3:0] cmd_kind,
    input wire [127:0] cmd_word,
    input wire [63:0] cmd_addr,
    input wire [15:0] cmd_virtual_machine_tag,
    input wire [15:0] cmd_address_space_tag,
    input wire cmd_last_level_only,
    input wire cmd_secure_queue,
    // Configuration
    input wire range_invalidate_support,
    input wire broadcast_maintenance_support,
    input wire stage1_support,
    input wire hyp_support,
    input wire host_extension_mode,
    input wire ns_stage2_support,
    input wire sec_stage2_support,
    input wire top_byte_ignore,
    input wire range_check_enable,
    input wire [6:0] virtual_address_width,
    // Error report
    output reg illegal_command_error,
    // Request to TLB match logic
    output reg inv_valid,
    output reg inv_by_address,
    output reg [63:0] inv_start,
    output reg [64:0] inv_end,
    output reg [1:0] inv_granule,
    output reg [1:0] inv_level_hint,
    output reg inv_last_level,
    output reg [2:0] translation_regime_tag,
    output reg inv_match_vm_tag,
    output reg [15:0] inv_virtual_machine_tag,
    output reg inv_match_space_tag,
    output reg [15:0] inv_address_space_tag,
    output reg inv_broadcast_range_ok
);
    // ----------------------------------------
    // Field extraction
    // ----------------------------------------
    // Without the capability every range field reads as zero
    wire [1:0] gran = range_invalidate_support ? cmd_word[`TRD_GRAN_HI:`TRD_GRAN_LO] : 2'h0;
    wire [1:0] hint_raw = range_invalidate_support ? cmd_word[`TRD_HINT_HI:`TRD_HINT_LO] : 2'h0;
    wire ranged = (gran != `TRD_GRAN_ANY);
    wire [4:0] rexp = ranged ? cmd_word[`TRD_EXP_HI:`TRD_EXP_LO] : 5'h00;
    wire [4:0] rmul = ranged ? cmd_word[`TRD_MUL_HI:`TRD_MUL_LO] : 5'h00;

    function [1:0] eff_hint;
        input [1:0] g;
        input [1:0] h;
        begin
            if (g == `TRD_GRAN_ANY) begin
                eff_hint = `TRD_HINT_ANY;
            end else if (g == `TRD_GRAN_16K && h == `TRD_HINT_L1) begin
                eff_hint = `TRD_HINT_ANY;
            end else begin
                eff_hint = h;
            end
        end
    endfunction

    function is_addr_kind;
        input [3:0] k;
        begin
            is_addr_kind = (k == `TRD_OP_GUEST_VA_ALL) || (k == `TRD_OP_GUEST_VA) ||
                (k == `TRD_OP_MON_VA) || (k == `TRD_OP_HYP_VA) || (k == `TRD_OP_HYP_VA_ALL);
        end
    endfunction

    wire [1:0] hint = eff_hint(gran, hint_raw);
    wire addr_kind = is_addr_kind(cmd_kind);

    // ----------------------------------------
    // Address handling
    // ----------------------------------------
    // Top byte ignore sign-extends bit 55 over the tag byte
    wire [63:0] addr_tbi = top_byte_ignore ? {{8{cmd_addr[55]}}, cmd_addr[55:0]} : cmd_addr;
    reg out_of_range;
    integer i;
    always @* begin
        out_of_range = 1'b0;
        for (i = 1; i < 64; i = i + 1) begin
            if (range_check_enable && i >= virtual_address_width && virtual_address_width != 7'h00 &&
                addr_tbi[i] != addr_tbi[i - 1]) begin
                out_of_range = 1'b1;
            end
        end
    end

    wire [64:0] calc_end;
    trd_range_calc u_range (
        .start_addr(addr_tbi),
        .granule_select(gran),
        .range_exp(rexp),
        .range_mul(rmul),
        .end_addr(calc_end)
    );
    // Non-ranged commands cover a single address; the match logic widens it to the entry size
    wire [64:0] one_end = {1'h0, addr_tbi} + 65'h1;
    wire [64:0] end_sel = ranged ? calc_end : one_end;

    // ----------------------------------------
    // Legality and scope
    // ----------------------------------------
    reg illegal;
    reg [2:0] regime;
    reg match_vm;
    reg match_space;
    wire s2_here = cmd_secure_queue ? sec_stage2_support : ns_stage2_support;
    always @* begin
        illegal = 1'b0;
        regime = `TRD_REG_NS_EL1;
        match_vm = 1'b0;
        match_space = 1'b0;
        case (cmd_kind)
            `TRD_OP_GUEST_ALL, `TRD_OP_GUEST_SPACE, `TRD_OP_GUEST_VA_ALL, `TRD_OP_GUEST_VA: begin
                regime = cmd_secure_queue ? `TRD_REG_SEC : `TRD_REG_NS_EL1;
                match_vm = s2_here;
                match_space = (cmd_kind == `TRD_OP_GUEST_SPACE) || (cmd_kind == `TRD_OP_GUEST_VA);
            end
            `TRD_OP_MON_ALL, `TRD_OP_MON_VA: begin
                regime = `TRD_REG_EL3;
                illegal = !cmd_secure_queue;
            end
            `TRD_OP_HYP_ALL, `TRD_OP_HYP_VA, `TRD_OP_HYP_VA_ALL, `TRD_OP_HYP_SPACE: begin
                regime = host_extension_mode ? `TRD_REG_EL2_HOST : `TRD_REG_EL2;
                illegal = !hyp_support;
                match_space = host_extension_mode &&
                    ((cmd_kind == `TRD_OP_HYP_VA) || (cmd_kind == `TRD_OP_HYP_SPACE));
            end
            default: begin
                illegal = 1'b1;
            end
        endcase
        if (!stage1_support) begin
            illegal = 1'b1;
        end
        if (addr_kind && ranged && rmul == 5'h00 && rexp == 5'h00 && hint_raw == `TRD_HINT_ANY) begin
            illegal = 1'b1;
        end
    end

    // ----------------------------------------
    // Registered outputs
    // ----------------------------------------
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            illegal_command_error <= 1'b0;
            inv_valid <= 1'b0;
            inv_by_address <= 1'b0;
            inv_start <= `TRD_ZERO_ADDR;
            inv_end <= `TRD_ZERO_END;
            inv_granule <= `TRD_GRAN_ANY;
            inv_level_hint <= `TRD_HINT_ANY;
            inv_last_level <= 1'b0;
            translation_regime_tag <= `TRD_REG_NS_EL1;
            inv_match_vm_tag <= 1'b0;
            inv_virtual_machine_tag <= 16'h0000;
            inv_match_space_tag <= 1'b0;
            inv_address_space_tag <= 16'h0000;
            inv_broadcast_range_ok <= 1'b0;
        end else begin
            inv_broadcast_range_ok <= broadcast_maintenance_support && range_invalidate_support;
            illegal_command_error <= cmd_valid && illegal;
            // Out-of-range addresses are dropped as a no-op, not an error
            inv_valid <= cmd_valid && !illegal && !(addr_kind && out_of_range);
            if (cmd_valid && !illegal) begin
                inv_by_address <= addr_kind;
                inv_start <= addr_tbi;
                inv_end <= end_sel;
                inv_granule <= gran;
                inv_level_hint <= hint;
                // Leaf=0 lets the match logic also drop table entries above the hint level
                inv_last_level <= cmd_last_level_only;
                translation_regime_tag <= regime;
                inv_match_vm_tag <= match_vm;
                inv_virtual_machine_tag <= match_vm ? cmd_virtual_machine_tag : 16'h0000;
                inv_match_space_tag <= match_space;
                inv_address_space_tag <= cmd_address_space_tag;
            end
        end
    end
endmodule // trd_decode

// file: test/trd_decode_properties.sv
`timescale 1ns/10ps
module trd_decode_properties (
    // Clock and reset
    input wire ref_clk,
    input wire rst_b,
    // Command and configuration
    input wire cmd_valid,
    input wire [3:0] cmd_kind,
    input wire [127:0] cmd_word,
    input wire cmd_secure_queue,
    input wire range_invalidate_support,
    input wire broadcast_maintenance_support,
    input wire stage1_support,
    input wire hyp_support,
    // Decoder outputs
    input wire illegal_command_error,
    input wire inv_valid,
    input wire inv_by_address,
    input wire [63:0] inv_start,
    input wire [64:0] inv_end,
    input wire [1:0] inv_granule,
    input wire [1:0] inv_level_hint,
    input wire inv_broadcast_range_ok
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // ----------------------------------------
    // Refusal sequences
    // ----------------------------------------
    sequence s_refuse;
        illegal_command_error && !inv_valid;
    endsequence
    sequence s_ns_monitor;
        cmd_valid && !cmd_secure_queue && (cmd_kind == 4'h4 || cmd_kind == 4'h5);
    endsequence
    // Address kinds only; the raw hint is what counts here
    sequence s_reserved;
        cmd_valid && range_invalidate_support && cmd_kind inside {4'h2, 4'h3, 4'h5, 4'h7, 4'h8}
            && cmd_word[75:74] != 2'h0 && cmd_word[73:72] == 2'h0 && cmd_word[24:20] == 5'h0
            && cmd_word[16:12] == 5'h0;
    endsequence
    chk_no_stage1_ill: assert property (cmd_valid && !stage1_support |=> s_refuse)
        else $error("stage 1 command not refused");
    chk_monitor_ns_ill: assert property (s_ns_monitor |=> s_refuse)
        else $error("monitor command on nonsecure queue not refused");
    chk_hyp_off_ill: assert property (cmd_valid && !hyp_support &&
        cmd_kind >= 4'h6 && cmd_kind <= 4'h9 |=> s_refuse)
        else $error("hyp command without support not refused");
    chk_reserved_combo_ill: assert property (s_reserved |=> s_refuse)
        else $error("reserved range combination not refused");
    chk_pulse_exclusive: assert property (!(inv_valid && illegal_command_error))
        else $error("forward and refusal in one cycle");
    chk_answer_has_cause: assert property (inv_valid || illegal_command_error |-> $past(cmd_valid))
        else $error("answer without a command");
    chk_any_gran_single: assert property (inv_valid && inv_by_address && inv_granule == 2'h0
        |-> inv_end == {1'b0, inv_start} + 65'h1 && inv_level_hint == 2'h0)
        else $error("granule zero request not single address");
    chk_hint_16k_fold: assert property (inv_valid && inv_granule == 2'h2 |-> inv_level_hint != 2'h1)
        else $error("reserved 16K hint forwarded");
    chk_end_above_start: assert property (inv_valid && inv_by_address |-> inv_end > {1'b0, inv_start})
        else $error("range end not above start");
    chk_no_range_fields: assert property (inv_valid && !$past(range_invalidate_support) |-> inv_granule == 2'h0)
        else $error("granule used without range support");
    chk_bcast_range_ok: assert property ((broadcast_maintenance_support && range_invalidate_support) [*2]
        |=> inv_broadcast_range_ok)
        else $error("broadcast range support not flagged");
endmodule // trd_decode_properties

// file: test/trd_tlb_model.sv
`timescale 1ns/10ps
// One cached entry; reports whether the forwarded request removes it
module trd_tlb_model #(
    parameter [63:0] ENTRY_ADDR = 64'h0000_7F00_0001_0000,
    parameter [1:0] ENTRY_GRAN = 2'h3,
    parameter [2:0] ENTRY_REGIME = 3'h0
) (
    // Request from decoder
    input wire inv_valid,
    input wire [63:0] inv_start,
    input wire [64:0] inv_end,
    input wire [1:0] inv_granule,
    input wire [2:0] translation_regime_tag,
    // Entry removed
    output wire tlb_hit
);
    // 65-bit compare so a saturated end never wraps into the low half
    assign tlb_hit = inv_valid && {1'b0, ENTRY_ADDR} >= {1'b0, inv_start} && {1'b0, ENTRY_ADDR} < inv_end
        && (inv_granule == 2'h0 || inv_granule == ENTRY_GRAN) && translation_regime_tag == ENTRY_REGIME;
endmodule // trd_tlb_model

// file: test/tb_tlb_range_invalidate_decode.sv
`timescale 1ns/10ps
module tb_tlb_range_invalidate_decode;
    reg ref_clk = 1'b0;
    reg rst_b = 1'b0;
    reg cmd_valid = 1'b0, cmd_secure_queue = 1'b0, cmd_last_level_only = 1'b0;
    reg [3:0] cmd_kind = 4'h0;
    reg [127:0] cmd_word = 128'h0;
    reg [63:0] cmd_addr = 64'h0;
    reg [15:0] cmd_virtual_machine_tag = 16'h0, cmd_address_space_tag = 16'h0;
    reg range_invalidate_support = 1'b1, broadcast_maintenance_support = 1'b1, stage1_support = 1'b1;
    reg hyp_support = 1'b1, host_extension_mode = 1'b0, ns_stage2_support = 1'b1, sec_stage2_support = 1'b0;
    reg top_byte_ignore = 1'b0, range_check_enable = 1'b0;
    reg [6:0] virtual_address_width = 7'h0;
    wire illegal_command_error, inv_valid, inv_by_address, inv_last_level, inv_match_vm_tag;
    wire inv_match_space_tag, inv_broadcast_range_ok, tlb_hit;
    wire [63:0] inv_start;
    wire [64:0] inv_end;
    wire [1:0] inv_granule, inv_level_hint;
    wire [2:0] translation_regime_tag;
    wire [15:0] inv_virtual_machine_tag, inv_address_space_tag;
    integer err_count = 0, n_tests = 0, cyc = 0;
    // Aligned for every granule and hint used below
    localparam [63:0] A = 64'h0000_7F00_0000_0000;

    trd_decode i_dut (.*);
    trd_tlb_model i_tlb (.*);

    always #4 ref_clk = ~ref_clk;

    task wrap_up;
        begin
            if (err_count == 0 && n_tests > 0) begin
                $display("Run complete: PASS");
            end else begin
                $display("Run complete: FAIL");
            end
            $finish;
        end
    endtask

    // Hang guard, far above the roughly fifty cycles the run needs
    always @(posedge ref_clk) begin
        cyc = cyc + 1;
        if (cyc == 2000) begin
            err_count = err_count + 1;
            wrap_up;
        end
    end

    task automatic chk(input string n, input [64:0] e, input [64:0] g);
        begin
            n_tests = n_tests + 1;
            if (g !== e) begin
                err_count = err_count + 1;
                $display("unexpected %s expected %h seen %h", n, e, g);
            end
        end
    endtask

    // One command for one cycle; outputs are judged just after the answering edge
    task automatic issue(input [3:0] k, input sq, input [1:0] g, h, input [4:0] e, m, input [63:0] a);
        begin
            @(posedge ref_clk);
            #1;
            cmd_valid = 1'b1;
            cmd_kind = k;
            cmd_secure_queue = sq;
            cmd_addr = a;
            cmd_last_level_only = k[0];
            cmd_virtual_machine_tag = {12'h0, k};
            cmd_address_space_tag = {12'h0, g, h};
            cmd_word = 128'h0;
            cmd_word[75:72] = {g, h};
            cmd_word[24:20] = e;
            cmd_word[16:12] = m;
            @(posedge ref_clk);
            #1;
            cmd_valid = 1'b0;
        end
    endtask

    function automatic [64:0] xend(input [63:0] a, input [1:0] g, input [4:0] e, m);
        reg [64:0] s;
        begin
            s = {1'b0, a} + ((65'h0 + m + 1) << (e + 10 + 2 * g));
            xend = (s > 65'h1_0000_0000_0000_0000) ? 65'h1_0000_0000_0000_0000 : s;
        end
    endfunction

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_range;
        integer g;
        begin
            for (g = 1; g < 4; g = g + 1) begin
                issue(4'h3, 1'b0, g[1:0], 2'h3, 5'h3, 5'h2, A);
                chk("end", xend(A, g[1:0], 5'h3, 5'h2), inv_end);
                chk("start", A, inv_start);
                chk("granule", g, inv_granule);
                chk("hit", g == 3, tlb_hit);
            end
        end
    endtask

    task t_hint;
        reg [5:0] v;
        reg [29:0] tab;
        integer i;
        begin
            // Entries are granule, raw hint, forwarded hint
            tab = {6'h0C, 6'h15, 6'h24, 6'h3A, 6'h10};
            for (i = 0; i < 5; i = i + 1) begin
                v = tab[i * 6 +: 6];
                issue(4'h5, 1'b1, v[5:4], v[3:2], 5'h1, 5'h0, A);
                chk("hint", v[1:0], inv_level_hint);
                chk("regime", 3'h2, translation_regime_tag);
                chk("last", 1'b1, inv_last_level);
                if (v[5:4] == 2'h0) chk("end", {1'b0, A} + 65'h1, inv_end);
            end
        end
    endtask

    task t_scope;
        reg [11:0] v;
        reg [83:0] tab;
        integer i;
        begin
            // Entries are kind, queue/stage1/hyp/mode, refused/regime
            tab = {12'h360, 12'h3E1, 12'h468, 12'h748, 12'h774, 12'h6E3, 12'h028};
            for (i = 0; i < 7; i = i + 1) begin
                v = tab[i * 12 +: 12];
                {stage1_support, hyp_support, host_extension_mode} = v[6:4];
                issue(v[11:8], v[7], 2'h1, 2'h3, 5'h0, 5'h1, A);
                chk("refused", v[3], illegal_command_error);
                chk("forwarded", !v[3], inv_valid);
                if (!v[3]) begin
                    chk("regime", v[2:0], translation_regime_tag);
                    chk("last", v[8], inv_last_level);
                    chk("by_addr", v[11:8] != 4'h6, inv_by_address);
                    chk("space_match", v[11:8] == 4'h3 || (v[11:8] == 4'h7 && v[4]), inv_match_space_tag);
                    chk("space_tag", 16'h0007, inv_address_space_tag);
                end
                if (!v[3] && v[11:8] < 4) begin
                    chk("vm_match", !v[7], inv_match_vm_tag);
                    chk("vm_tag", v[7] ? 16'h0000 : {12'h000, v[11:8]}, inv_virtual_machine_tag);
                end
            end
            {stage1_support, hyp_support} = 2'h3;
        end
    endtask

    task t_edge;
        begin
            chk("bcast", 1'b1, inv_broadcast_range_ok);
            issue(4'h3, 1'b0, 2'h1, 2'h0, 5'h0, 5'h0, A);
            chk("reserved", 1'b1, illegal_command_error);
            issue(4'h3, 1'b0, 2'h1, 2'h3, 5'h0, 5'h1, 64'hFFFF_FFFF_FFFF_F000);
            chk("top_end", 65'h1_0000_0000_0000_0000, inv_end);
            top_byte_ignore = 1'b1;
            issue(4'h3, 1'b0, 2'h0, 2'h0, 5'h0, 5'h0, 64'hAB00_7F00_0000_0000);
            chk("tbi_start", A, inv_start);
            top_byte_ignore = 1'b0;
            range_check_enable = 1'b1;
            virtual_address_width = 7'h30;
            issue(4'h3, 1'b0, 2'h0, 2'h0, 5'h0, 5'h0, 64'h0001_0000_0000_0000);
            chk("out_of_range", 1'b0, inv_valid || illegal_command_error);
            issue(4'h3, 1'b0, 2'h0, 2'h0, 5'h0, 5'h0, A);
            chk("in_range", 1'b1, inv_valid);
            range_check_enable = 1'b0;
            issue(4'hA, 1'b0, 2'h0, 2'h0, 5'h0, 5'h0, A);
            chk("bad_kind", 1'b1, illegal_command_error);
            range_invalidate_support = 1'b0;
            issue(4'h3, 1'b0, 2'h3, 2'h2, 5'h4, 5'h4, A);
            chk("granule_off", 2'h0, inv_granule);
            chk("end_off", {1'b0, A} + 65'h1, inv_end);
            chk("bcast_off", 1'b0, inv_broadcast_range_ok);
        end
    endtask

    initial begin
        repeat (4) @(posedge ref_clk);
        #1;
        rst_b = 1'b1;
        t_range;
        t_hint;
        t_scope;
        t_edge;
        wrap_up;
    end
endmodule // tb_tlb_range_invalidate_decode

bind trd_decode trd_decode_properties i_chk (.*);
